/* File: rtl/hbds_pkg.sv */
// Types shared by the H-bridge drive sequencer
package hbds_pkg;

  // Protection state of the bridge
  typedef enum logic [1:0] {
    HBDS_OFF   = 2'b00,
    HBDS_RUN   = 2'b01,
    HBDS_RETRY = 2'b10,
    HBDS_HOT   = 2'b11
  } hbds_state_t;

endpackage

/* File: rtl/hbds_regs.svh */
// Timing constants and reset values for the H-bridge drive sequencer
`ifndef HBDS_REGS_SVH
`define HBDS_REGS_SVH

// Reference clock rate
`define HBDS_CLK_KHZ        100000
// Internal oscillator switching rate, half period rounded down
`define HBDS_OSC_KHZ        425
`define HBDS_OSC_HALF_CYC   (`HBDS_CLK_KHZ / (2 * `HBDS_OSC_KHZ))
// Crossover gap, least time, rounded up
`define HBDS_GAP_NS         30
`define HBDS_GAP_CYC        ((`HBDS_GAP_NS * `HBDS_CLK_KHZ + 999999) / 1000000)
// Watchdog timeout, least time, rounded up
`define HBDS_WDOG_US        20
`define HBDS_WDOG_CYC       ((`HBDS_WDOG_US * `HBDS_CLK_KHZ + 999) / 1000)
// Limit blanking time and retry wait time
`define HBDS_BLANK_US       1200
`define HBDS_BLANK_CYC      ((`HBDS_BLANK_US * `HBDS_CLK_KHZ) / 1000)
`define HBDS_RETRY_US       38400
// Scale the clock down first: the plain product overflows a 32-bit int
`define HBDS_RETRY_CYC      (`HBDS_RETRY_US * (`HBDS_CLK_KHZ / 1000))
// Reset values
`define HBDS_PHASE_RST      1'b0
`define HBDS_EXT_MODE_RST   1'b0

`endif

/* File: rtl/hbds_sequencer.sv */
// H-bridge drive sequencer: clock source, gap timing and protection
//
// How it works
// - Grounded clock pin selects internal oscillator; a toggling pin selects the pin clock.
// - Internal mode toggles the phase at about 425 kHz, equal halves.
// - External mode divides the pin clock by two with one toggle flop.
// - External mode changes phase only on rising pin edges.
// - No pin edge for the watchdog time returns to internal oscillator.
// - Each phase change floats both outputs for the gap before driving.
// - Disabled device floats both drive outputs.
// - Low supply indication forces disable mode with outputs floating.
// - Current at limit past blanking time stops drivers, pulls fault low.
// - After retry wait the drivers restart on their own.
// - Fault flag releases at restart, so it toggles under steady overload.
// - Fault flag is pulled low while protection holds the device off.
// - Over-temperature stops drivers; fault stays low the whole episode.
// - Switching resumes when the cool indication shows below 150 C, or after disable mode once hot clears.
// - Enable pin is active low; high disables the device.
`timescale 1ns/1ps
`include "hbds_regs.svh"
module hbds_sequencer import hbds_pkg::*; #(
  parameter int BLANK_CYC = `HBDS_BLANK_CYC,
  parameter int RETRY_CYC = `HBDS_RETRY_CYC
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic nrst,
  // Pins from the board
  input  wire logic clk_pin,
  input  wire logic enable_n,
  // Analog indications, already on ref_clk
  input  wire logic low_supply,
  input  wire logic over_limit,
  input  wire logic temp_hot,
  input  wire logic temp_cool,
  // Bridge outputs, enable low while driven
  output logic      drive_out_a,
  output logic      drive_out_a_oe_n,
  output logic      drive_out_b,
  output logic      drive_out_b_oe_n,
  // Open-drain fault flag, enable low pulls the line low
  output logic      fault_n_o,
  output logic      fault_n_oe_n,
  // Status
  output logic      ext_clk_active,
  output hbds_state_t prot_state
);

  localparam int HALF_CYC = `HBDS_OSC_HALF_CYC;
  localparam int GAP_CYC  = `HBDS_GAP_CYC;
  localparam int WDOG_CYC = `HBDS_WDOG_CYC;
  localparam int OSC_W    = $clog2(HALF_CYC + 1);
  localparam int GAP_W    = $clog2(GAP_CYC + 1);
  localparam int WDOG_W   = $clog2(WDOG_CYC + 1);
  localparam int LONG_W   = $clog2(((BLANK_CYC > RETRY_CYC) ?
                                    BLANK_CYC : RETRY_CYC) + 1);

  // Saturating compare of a long counter against a cycle count
  function automatic logic long_done(input logic [LONG_W-1:0] cnt,
                                     input int                lim);
    long_done = (cnt >= LONG_W'(lim - 1));
  endfunction

  logic              pin_rise;
  logic              pin_edge;
  logic              en_lvl_n;

  logic [OSC_W-1:0]  osc_cnt_ff;
  logic [WDOG_W-1:0] wdog_cnt_ff;
  logic              ext_mode_ff;
  logic              src_phase_ff;
  logic              drv_phase_ff;
  logic [GAP_W-1:0]  gap_cnt_ff;
  logic              oe_n_ff;
  logic              out_a_ff;
  logic              out_b_ff;
  logic              fault_ff;
  logic [LONG_W-1:0] long_cnt_ff;
  hbds_state_t       state_ff;
  hbds_state_t       nxt_state;
  logic              run;
  logic              osc_tick;

  // Clock pin passes two flops before any logic sees it
  hbds_sync u_clk_sync (
    .ref_clk  (ref_clk),
    .nrst     (nrst),
    .async_in (clk_pin),
    .level    (),
    .rise     (pin_rise),
    .any_edge (pin_edge)
  );

  // Enable pin synchronised the same way; it idles high, so the flops
  // start disabled and the bridge cannot run before the pin is seen
  hbds_sync #(
    .RST_LVL (1'b1)
  ) u_en_sync (
    .ref_clk  (ref_clk),
    .nrst     (nrst),
    .async_in (enable_n),
    .level    (en_lvl_n),
    .rise     (),
    .any_edge ()
  );

  // Internal oscillator runs free so a fallback starts without delay
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      osc_cnt_ff <= '0;
    end else if (osc_tick) begin
      osc_cnt_ff <= '0;
    end else begin
      osc_cnt_ff <= osc_cnt_ff + OSC_W'(1);
    end
  end

  assign osc_tick = (osc_cnt_ff == OSC_W'(HALF_CYC - 1));

  // Watchdog measures time between any two pin edges
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wdog_cnt_ff <= '0;
    end else if (pin_edge) begin
      wdog_cnt_ff <= '0;
    end else if (wdog_cnt_ff != WDOG_W'(WDOG_CYC)) begin
      wdog_cnt_ff <= wdog_cnt_ff + WDOG_W'(1);
    end
  end

  // Source select: a rising pin edge claims the bridge, a timeout drops it
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ext_mode_ff <= `HBDS_EXT_MODE_RST;
    end else if (pin_rise) begin
      ext_mode_ff <= 1'b1;
    end else if (wdog_cnt_ff == WDOG_W'(WDOG_CYC)) begin
      ext_mode_ff <= 1'b0;
    end
  end

  // Phase flop: one toggle per source event gives an exact 50% split
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      src_phase_ff <= `HBDS_PHASE_RST;
    end else if (ext_mode_ff) begin
      if (pin_rise) begin
        src_phase_ff <= ~src_phase_ff;
      end
    end else if (osc_tick) begin
      src_phase_ff <= ~src_phase_ff;
    end
  end

  // Protection state; disable mode outranks every other condition
  always_comb begin
    nxt_state = state_ff;
    if (en_lvl_n || low_supply) begin
      nxt_state = HBDS_OFF;
    end else begin
      case (state_ff)
        HBDS_OFF: begin
          nxt_state = temp_hot ? HBDS_HOT : HBDS_RUN;
        end
        HBDS_RUN: begin
          if (temp_hot) begin
            nxt_state = HBDS_HOT;
          end else if (over_limit && long_done(long_cnt_ff, BLANK_CYC)) begin
            nxt_state = HBDS_RETRY;
          end
        end
        HBDS_RETRY: begin
          if (temp_hot) begin
            nxt_state = HBDS_HOT;
          end else if (long_done(long_cnt_ff, RETRY_CYC)) begin
            nxt_state = HBDS_RUN;
          end
        end
        HBDS_HOT: begin
          if (temp_cool && !temp_hot) begin
            nxt_state = HBDS_RUN;
          end
        end
        default: begin
          nxt_state = HBDS_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= HBDS_OFF;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Shared counter: blanking time in run, retry wait in retry
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      long_cnt_ff <= '0;
    end else if (nxt_state != state_ff) begin
      long_cnt_ff <= '0;
    end else if (state_ff == HBDS_RUN && !over_limit) begin
      long_cnt_ff <= '0;
    end else if (state_ff == HBDS_RUN || state_ff == HBDS_RETRY) begin
      long_cnt_ff <= long_cnt_ff + LONG_W'(1);
    end
  end

  assign run = (state_ff == HBDS_RUN);

  // Fault flag low only while protection holds the bridge off
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      fault_ff <= 1'b0;
    end else begin
      fault_ff <= (nxt_state == HBDS_RETRY) ||
                  (nxt_state == HBDS_HOT);
    end
  end

  // Output stage: float both legs for the gap at every phase change
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      drv_phase_ff <= `HBDS_PHASE_RST;
      gap_cnt_ff   <= '0;
      oe_n_ff      <= 1'b1;
      out_a_ff     <= 1'b0;
      out_b_ff     <= 1'b0;
    end else if (!run) begin
      drv_phase_ff <= src_phase_ff;
      gap_cnt_ff   <= '0;
      oe_n_ff      <= 1'b1;
    end else if (src_phase_ff != drv_phase_ff) begin
      oe_n_ff <= 1'b1;
      if (gap_cnt_ff == GAP_W'(GAP_CYC - 1)) begin
        drv_phase_ff <= src_phase_ff;
        gap_cnt_ff   <= '0;
      end else begin
        gap_cnt_ff <= gap_cnt_ff + GAP_W'(1);
      end
    end else begin
      oe_n_ff  <= 1'b0;
      out_a_ff <= drv_phase_ff;
      out_b_ff <= ~drv_phase_ff;
    end
  end

  // Pin outputs; the fault line is only ever pulled low
  assign drive_out_a      = out_a_ff;
  assign drive_out_b      = out_b_ff;
  assign drive_out_a_oe_n = oe_n_ff;
  assign drive_out_b_oe_n = oe_n_ff;
  assign fault_n_o        = 1'b0;
  assign fault_n_oe_n     = ~fault_ff;
  assign ext_clk_active   = ext_mode_ff;
  assign prot_state       = state_ff;

endmodule

/* File: rtl/hbds_sync.sv */
// Two-flop synchroniser with a third flop for edge detection
`timescale 1ns/1ps
module hbds_sync #(
  // Level the flops hold in reset; set to the pin's idle level
  parameter logic RST_LVL = 1'b0
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic nrst,
  // Asynchronous level in
  input  wire logic async_in,
  // Synchronised level and edges
  output logic      level,
  output logic      rise,
  output logic      any_edge
);

  logic meta_ff;
  logic sync_ff;
  logic hist_ff;

  // Only sync_ff reads meta_ff; edges come from the settled flops
  // Starting at the idle level avoids a false level or edge after reset
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      meta_ff <= RST_LVL;
      sync_ff <= RST_LVL;
      hist_ff <= RST_LVL;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
      hist_ff <= sync_ff;
    end
  end

  // Edge outputs are one-cycle pulses
  assign level    = sync_ff;
  assign rise     = sync_ff & ~hist_ff;
  assign any_edge = sync_ff ^ hist_ff;

endmodule

/* File: sim/hbds_checker.sv */
// Port assertions for the H-bridge drive sequencer
`timescale 1ns/1ps
module hbds_checker import hbds_pkg::*; #(
  parameter int BLANK_CYC = 20,
  parameter int RETRY_CYC = 60
) (
  // Clock and reset
  input wire logic  ref_clk,
  input wire logic  nrst,
  // Pins and indications
  input wire logic  clk_pin,
  input wire logic  enable_n,
  input wire logic  low_supply,
  input wire logic  over_limit,
  input wire logic  temp_hot,
  input wire logic  temp_cool,
  // Bridge, fault flag and status
  input wire logic  drive_out_a,
  input wire logic  drive_out_a_oe_n,
  input wire logic  drive_out_b,
  input wire logic  drive_out_b_oe_n,
  input wire logic  fault_n_o,
  input wire logic  fault_n_oe_n,
  input wire logic  ext_clk_active,
  input hbds_state_t prot_state
);
  int ol_cnt_ff;
  int rt_cnt_ff;
  int idle_cnt_ff;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // Run lengths of overload, retry and a quiet pin, kept as plain counts
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ol_cnt_ff   <= 0;
      rt_cnt_ff   <= 0;
      idle_cnt_ff <= 0;
    end else begin
      ol_cnt_ff   <= (over_limit && prot_state == HBDS_RUN) ?
                     ol_cnt_ff + 1 : 0;
      rt_cnt_ff   <= (prot_state == HBDS_RETRY) ? rt_cnt_ff + 1 : 0;
      idle_cnt_ff <= (clk_pin == $past(clk_pin)) ? idle_cnt_ff + 1 : 0;
    end
  end
  // Gap: three floating cycles, unless protection takes over meanwhile
  sequence s_gap;
    drive_out_a_oe_n[*3] ##1 (!drive_out_a_oe_n || prot_state != HBDS_RUN);
  endsequence
  a_gap_length: assert property ($rose(drive_out_a_oe_n) &&
    prot_state == HBDS_RUN |-> s_gap) else $error("gap length off");
  a_level_floats: assert property ($changed({drive_out_a, drive_out_b})
    |-> $past(drive_out_a_oe_n) && $past(drive_out_b_oe_n))
    else $error("level moved");
  a_legs_opposite: assert property (!drive_out_a_oe_n
    |-> drive_out_a != drive_out_b) else $error("legs not opposite");
  a_off_floats: assert property (prot_state != HBDS_RUN
    |=> drive_out_a_oe_n && drive_out_b_oe_n) else $error("driven off");
  a_low_supply_off: assert property (low_supply
    |=> prot_state == HBDS_OFF) else $error("low supply ignored");
  a_enable_pin_off: assert property (enable_n[*3]
    |=> prot_state == HBDS_OFF) else $error("enable pin ignored");
  a_blank_trip: assert property (prot_state == HBDS_RUN &&
    over_limit && ol_cnt_ff == BLANK_CYC - 1 |=> prot_state != HBDS_RUN)
    else $error("no trip");
  a_no_early_trip: assert property ($rose(prot_state == HBDS_RETRY)
    |-> $past(ol_cnt_ff) >= BLANK_CYC - 1) else $error("early trip");
  a_retry_length: assert property (prot_state == HBDS_RUN &&
    $past(prot_state) == HBDS_RETRY |-> rt_cnt_ff == RETRY_CYC)
    else $error("retry wait off");
  a_fault_flag: assert property (!fault_n_o && fault_n_oe_n ==
    !(prot_state inside {HBDS_RETRY, HBDS_HOT})) else $error("fault flag");
  a_hot_entry: assert property (prot_state == HBDS_RUN && temp_hot
    |=> prot_state != HBDS_RUN) else $error("hot ignored");
  a_hot_hold: assert property (prot_state == HBDS_HOT && !temp_cool
    |=> prot_state != HBDS_RUN) else $error("hot left early");
  a_wdog_fallback: assert property (idle_cnt_ff > 2010
    |-> !ext_clk_active) else $error("watchdog missed");
endmodule
bind hbds_sequencer hbds_checker #(.BLANK_CYC(BLANK_CYC),
  .RETRY_CYC(RETRY_CYC)) u_hbds_checker (.ref_clk(ref_clk), .nrst(nrst),
  .clk_pin(clk_pin), .enable_n(enable_n), .low_supply(low_supply),
  .over_limit(over_limit), .temp_hot(temp_hot), .temp_cool(temp_cool),
  .drive_out_a(drive_out_a), .drive_out_a_oe_n(drive_out_a_oe_n),
  .drive_out_b(drive_out_b), .drive_out_b_oe_n(drive_out_b_oe_n),
  .fault_n_o(fault_n_o), .fault_n_oe_n(fault_n_oe_n),
  .ext_clk_active(ext_clk_active), .prot_state(prot_state));

/* File: sim/hbds_primary.sv */
// Transformer primary seen from the two bridge legs
`timescale 1ns/1ps
module hbds_primary (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic nrst,
  // Bridge legs
  input  wire logic leg_a,
  input  wire logic leg_a_oe_n,
  input  wire logic leg_b,
  input  wire logic leg_b_oe_n,
  // Core flux still bounded
  output logic      balanced
);
  int flux;
  // Net volt-seconds; unequal halves walk the core into saturation
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) flux <= 0;
    else if (!leg_a_oe_n && !leg_b_oe_n) flux <= flux + (leg_a ? 1 : -1);
  end
  assign balanced = (flux <= 130) && (flux >= -130);
endmodule

/* File: sim/tb_hbds_sequencer.sv */
// Self-checking testbench for the H-bridge drive sequencer
`timescale 1ns/1ps
module tb_hbds_sequencer import hbds_pkg::*;;
  logic        ref_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        clk_pin = 1'b0;
  logic        enable_n = 1'b1;
  logic        low_supply = 1'b0;
  logic        over_limit = 1'b0;
  logic        temp_hot = 1'b0;
  logic        temp_cool = 1'b1;
  logic        pin_run = 1'b0;
  logic        a, a_oe_n, b, b_oe_n, f_o, f_oe_n, ext, bal;
  hbds_state_t st;
  int          num_errors = 0;
  int          checked = 0;
  int          n;
  int          pc = 0;
  always #5 ref_clk = ~ref_clk;
  // Board clock of 60 cycles period, held still when stopped
  always @(posedge ref_clk) begin
    pc <= (pc == 29) ? 0 : pc + 1;
    if (pin_run && pc == 29) clk_pin <= ~clk_pin;
  end
  hbds_sequencer #(.BLANK_CYC(20), .RETRY_CYC(60)) u_hbds_sequencer (
    .ref_clk(ref_clk), .nrst(nrst), .clk_pin(clk_pin), .enable_n(enable_n),
    .low_supply(low_supply), .over_limit(over_limit), .temp_hot(temp_hot),
    .temp_cool(temp_cool), .drive_out_a(a), .drive_out_a_oe_n(a_oe_n),
    .drive_out_b(b), .drive_out_b_oe_n(b_oe_n), .fault_n_o(f_o),
    .fault_n_oe_n(f_oe_n), .ext_clk_active(ext), .prot_state(st));
  hbds_primary u_hbds_primary (.ref_clk(ref_clk), .nrst(nrst), .leg_a(a),
    .leg_a_oe_n(a_oe_n), .leg_b(b), .leg_b_oe_n(b_oe_n), .balanced(bal));
  task automatic check(logic [15:0] seen, logic [15:0] exp, string what);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask
  // Sample a little after the edge so its updates have landed
  task automatic cyc(int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  // Cycles between two phase flips; bounded so a stuck phase ends it
  task automatic meas(output int k);
    logic p;
    k = 0;
    cyc(1);
    p = a;
    while (a === p && k < 5000) begin cyc(1); k++; end
    p = a;
    k = 0;
    while (a === p && k < 5000) begin cyc(1); k++; end
  endtask
  task automatic conclude;
    $display("checks %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Cut a hang short at several times the expected run length
  initial begin
    repeat (20000) @(posedge ref_clk);
    num_errors++;
    conclude;
  end
  initial begin
    repeat (8) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk) enable_n <= 1'b0;
    cyc(8);
    check(st, HBDS_RUN, "state");
    check(ext, 1'b0, "source");
    meas(n);
    check(n, 117, "osc half");
    n = 0;
    while (a_oe_n !== 1'b1 && n < 500) begin cyc(1); n++; end
    n = 0;
    while (a_oe_n === 1'b1 && n < 9) begin cyc(1); n++; end
    check(n, 3, "gap");
    check(a ^ b, 1'b1, "legs");
    check(bal, 1'b1, "flux");
    $display("test internal done");
    @(posedge ref_clk) pin_run <= 1'b1;
    cyc(200);
    check(ext, 1'b1, "source");
    meas(n);
    check(n, 60, "ext half");
    @(posedge ref_clk) pin_run <= 1'b0;
    cyc(2100);
    check(ext, 1'b0, "watchdog");
    meas(n);
    check(n, 117, "fallback half");
    $display("test external done");
    @(posedge ref_clk) over_limit <= 1'b1;
    cyc(10);
    @(posedge ref_clk) over_limit <= 1'b0;
    cyc(30);
    check(st, HBDS_RUN, "short overload");
    @(posedge ref_clk) over_limit <= 1'b1;
    cyc(25);
    check(st, HBDS_RETRY, "trip");
    check({a_oe_n, f_oe_n, f_o}, 3'b100, "tripped pins");
    @(posedge ref_clk) over_limit <= 1'b0;
    cyc(60);
    check({st, f_oe_n}, {HBDS_RUN, 1'b1}, "retry");
    $display("test overload done");
    @(posedge ref_clk) {temp_hot, temp_cool} <= 2'b10;
    cyc(3);
    check({st, f_oe_n, a_oe_n}, {HBDS_HOT, 2'b01}, "hot");
    @(posedge ref_clk) temp_hot <= 1'b0;
    cyc(50);
    check({st, f_oe_n}, {HBDS_HOT, 1'b0}, "hysteresis");
    @(posedge ref_clk) temp_cool <= 1'b1;
    cyc(3);
    check({st, f_oe_n}, {HBDS_RUN, 1'b1}, "cooled");
    $display("test thermal done");
    @(posedge ref_clk) low_supply <= 1'b1;
    cyc(2);
    check({st, a_oe_n, f_oe_n}, {HBDS_OFF, 2'b11}, "low supply");
    @(posedge ref_clk) low_supply <= 1'b0;
    cyc(5);
    check(st, HBDS_RUN, "supply back");
    @(posedge ref_clk) enable_n <= 1'b1;
    cyc(5);
    check({st, a_oe_n, b_oe_n}, {HBDS_OFF, 2'b11}, "disabled");
    $display("test disable done");
    conclude;
  end
endmodule
